// ==== design/qrst_switch_timing.sv ====
// gate timing core: start-up, soft-start, valley switching, limits and latch-off
`timescale 1ns/100ps
`include "qrst_consts.svh"
module qrst_switch_timing
    import qrst_pkg::*;
#(
    parameter logic [22:0] FB_PERIOD_CYC = 23'(`QRST_FB_PERIOD_CYC),
    parameter logic [18:0] SS_STEP_CYC = 19'(`QRST_SS_STEP_CYC),
    parameter logic [15:0] MAX_OFF_CYC = 16'(`QRST_MAX_OFF_CYC)
)(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic supply_above_on,
    input wire logic fb_above_low,
    input wire logic fb_above_high,
    input wire logic fb_above_reset,
    input wire logic line_high,
    input wire logic cs_trip,
    input wire logic zc_above_zero,
    input wire logic zc_above_ovp,
    output logic gate_drive_output,
    output logic startup_source_en,
    output logic fb_thr_line_sel,
    output logic softstart_active,
    output logic [1:0] peak_limit_step,
    output qrst_count_t valley_index,
    output qrst_count_t zc_count,
    output logic latched_off
);
    localparam logic [15:0] RING_CYC = 16'(`QRST_RING_CYC);
    localparam logic [15:0] MAX_ON_CYC = 16'(`QRST_MAX_ON_CYC);
    localparam logic [15:0] OVP_CYC = 16'(`QRST_OVP_BLANK_CYC);
    localparam int RING_INT = `QRST_RING_CYC;

    qrst_fb_if fbi ();

    logic [`QRST_SYNC_W-1:0] meta_q;
    logic [`QRST_SYNC_W-1:0] sync_q;
    logic [`QRST_SYNC_W-1:0] raw_in;
    logic supply_s;
    logic cs_s;
    logic zc_s;
    logic ovp_s;
    qrst_state_e state_q;
    qrst_state_e state_d;
    logic running;
    logic start_evt;
    logic [18:0] ss_cnt_q;
    logic [1:0] ss_step_q;
    logic ss_busy_q;
    logic ss_step_end;
    logic gate_q;
    logic [15:0] off_cnt_q;
    logic [15:0] on_cnt_q;
    logic ring_done;
    logic valley_ok;
    logic max_off_hit;
    logic max_on_hit;
    logic turn_on;
    logic turn_off;
    logic zc_prev_q;
    logic zc_fall;
    qrst_count_t zc_cnt_q;
    logic [15:0] ovp_cnt_q;
    logic ovp_trip;

    // every comparator is asynchronous to core_clk, so all pass two flops
    assign raw_in = {supply_above_on, fb_above_low, fb_above_high, fb_above_reset,
        line_high, cs_trip, zc_above_zero, zc_above_ovp};
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            meta_q <= 8'h00;
            sync_q <= 8'h00;
        end
        else
        begin
            meta_q <= raw_in;
            sync_q <= meta_q;
        end
    end

    // synchronised level names
    assign supply_s = sync_q[7];
    assign fbi.fb_low = sync_q[6];
    assign fbi.fb_high = sync_q[5];
    assign fbi.fb_reset = sync_q[4];
    assign fb_thr_line_sel = sync_q[3]; // analog picks threshold pair by line level
    assign cs_s = sync_q[2];
    assign zc_s = sync_q[1];
    assign ovp_s = sync_q[0];

    // operating state: wait for supply, run, or latched off until supply-off reset
    assign running = (state_q == QRST_RUN);
    assign start_evt = (state_q == QRST_WAIT) && supply_s;
    assign fbi.restart = start_evt;
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            QRST_WAIT: if (supply_s) state_d = QRST_RUN;
            QRST_RUN: if (ovp_trip) state_d = QRST_LATCH;
            QRST_LATCH: state_d = QRST_LATCH;
            default: state_d = QRST_WAIT;
        endcase
    end
    always_ff @(posedge core_clk)
    begin
        if (reset)
            state_q <= QRST_WAIT;
        else
            state_q <= state_d;
    end
    assign startup_source_en = (state_q == QRST_WAIT);
    assign latched_off = (state_q == QRST_LATCH);

    // soft-start: four equal timed steps of the peak limit, no feedback involved
    assign ss_step_end = (ss_cnt_q == SS_STEP_CYC - 19'h00001);
    always_ff @(posedge core_clk)
    begin
        if (reset || start_evt)
        begin
            ss_cnt_q <= 19'h00000;
            ss_step_q <= 2'h0; // lowest step is the 0.32V limit
            ss_busy_q <= start_evt;
        end
        else if (ss_busy_q)
        begin
            ss_cnt_q <= ss_step_end ? 19'h00000 : ss_cnt_q + 19'h00001;
            if (ss_step_end && ss_step_q == `QRST_SS_LAST_STEP)
                ss_busy_q <= 1'b0;
            else if (ss_step_end)
                ss_step_q <= ss_step_q + 2'h1;
        end
    end
    // last step is the 1V limit; the analog side takes the lower of this and foldback
    assign peak_limit_step = ss_step_q;
    assign softstart_active = ss_busy_q;

    // switching decisions: counters turn on, analog comparison turns off
    assign ring_done = (off_cnt_q >= RING_CYC);
    assign valley_ok = (zc_cnt_q >= fbi.valley_idx);
    assign max_off_hit = (off_cnt_q >= MAX_OFF_CYC - 16'h0001);
    assign max_on_hit = (on_cnt_q >= MAX_ON_CYC - 16'h0001);
    assign turn_on = running && !ovp_trip && !gate_q
        && ((ring_done && valley_ok) || max_off_hit);
    assign turn_off = gate_q && (cs_s || max_on_hit || !running);
    always_ff @(posedge core_clk)
    begin
        if (reset)
            gate_q <= 1'b0;
        else if (turn_on)
            gate_q <= 1'b1;
        else if (turn_off)
            gate_q <= 1'b0;
    end
    assign gate_drive_output = gate_q;

    // on and off time counters, saturating so they never wrap
    always_ff @(posedge core_clk)
    begin
        if (reset || gate_q || start_evt)
            off_cnt_q <= 16'h0000;
        else if (!max_off_hit)
            off_cnt_q <= off_cnt_q + 16'h0001;
        if (reset || !gate_q)
            on_cnt_q <= 16'h0000;
        else if (!max_on_hit)
            on_cnt_q <= on_cnt_q + 16'h0001;
    end

    // falling crossing of the 100mV level, seen only after the second flop
    assign zc_fall = zc_prev_q && !zc_s;
    always_ff @(posedge core_clk)
    begin
        if (reset)
            zc_prev_q <= 1'b0;
        else
            zc_prev_q <= zc_s;
    end
    always_ff @(posedge core_clk)
    begin
        if (reset || turn_on)
            zc_cnt_q <= 3'h0;
        else if (!gate_q && zc_fall && zc_cnt_q != `QRST_ZC_MAX)
            zc_cnt_q <= zc_cnt_q + 3'h1;
    end
    assign zc_count = zc_cnt_q;
    assign valley_index = fbi.valley_idx;

    // overvoltage must persist over the blanking time while off; a short spike resets it
    assign ovp_trip = ovp_s && !gate_q && (ovp_cnt_q >= OVP_CYC - 16'h0001);
    always_ff @(posedge core_clk)
    begin
        if (reset || gate_q || !ovp_s || !running)
            ovp_cnt_q <= 16'h0000;
        else if (!ovp_trip)
            ovp_cnt_q <= ovp_cnt_q + 16'h0001;
    end

    qrst_valley_counter #(
        .PERIOD_CYC(FB_PERIOD_CYC)
    ) u_valley (
        .core_clk(core_clk),
        .reset(reset),
        .fb(fbi.counter)
    );

    a_ring_hold_low: assert property (@(posedge core_clk) disable iff (reset)
        $rose(gate_q) |-> $past(off_cnt_q) >= RING_INT || $past(max_off_hit))
        else $error("gate rose inside ringing suppression");
    a_valley_turn_on: assert property (@(posedge core_clk) disable iff (reset)
        running && !gate_q && ring_done && valley_ok && !ovp_trip |=> gate_q)
        else $error("gate missed a valley turn-on");
    a_max_off_on: assert property (@(posedge core_clk) disable iff (reset)
        running && !gate_q && max_off_hit && !ovp_trip |=> gate_q)
        else $error("gate stayed off past max off time");
    a_max_on_off: assert property (@(posedge core_clk) disable iff (reset)
        gate_q && max_on_hit |=> !gate_q)
        else $error("gate stayed on past max on time");
    a_zc_clear_on: assert property (@(posedge core_clk) disable iff (reset)
        $rose(gate_q) |-> zc_cnt_q == 3'h0)
        else $error("crossing counter not cleared at turn-on");
    a_zc_count_fall: assert property (@(posedge core_clk) disable iff (reset)
        !gate_q && zc_fall && zc_cnt_q != 3'h7 && !turn_on
        |=> zc_cnt_q == $past(zc_cnt_q) + 3'h1)
        else $error("falling crossing not counted");
    a_latch_hold_low: assert property (@(posedge core_clk) disable iff (reset)
        latched_off |=> latched_off && !gate_q)
        else $error("latch released or gate driven while latched");
    a_ss_first_step: assert property (@(posedge core_clk) disable iff (reset)
        start_evt |=> softstart_active && peak_limit_step == 2'h0 && !startup_source_en)
        else $error("soft-start did not begin at the lowest step");

    // soft-start: the limit moves only at a step end and finishes on the top step,
    // so the analog side never sees a skipped or repeated step
    a_ss_step_adv: assert property (@(posedge core_clk) disable iff (reset)
        ss_busy_q && ss_step_end && ss_step_q != `QRST_SS_LAST_STEP
        |=> ss_step_q == $past(ss_step_q) + 2'h1)
        else $error("soft-start step did not advance at its end");
    a_ss_step_hold: assert property (@(posedge core_clk) disable iff (reset)
        !(ss_busy_q && ss_step_end) && !start_evt |=> $stable(ss_step_q))
        else $error("soft-start step moved between step ends");
    a_ss_end_top: assert property (@(posedge core_clk) disable iff (reset)
        $fell(softstart_active) |-> peak_limit_step == `QRST_SS_LAST_STEP)
        else $error("soft-start ended below the top step");

    // switching limits; the time counters saturate so a long off time never wraps
    // into a false ring-done, without any extra flops
    a_cs_turn_off: assert property (@(posedge core_clk) disable iff (reset)
        gate_q && cs_s |=> !gate_q)
        else $error("gate stayed on after the sense comparator tripped");
    a_ring_no_early: assert property (@(posedge core_clk) disable iff (reset)
        !gate_q && !ring_done && !max_off_hit |=> !gate_q)
        else $error("gate rose before ringing suppression ended");
    a_off_restart: assert property (@(posedge core_clk) disable iff (reset)
        $fell(gate_q) |-> off_cnt_q == 16'h0000)
        else $error("off time did not restart at turn-off");
    a_on_restart: assert property (@(posedge core_clk) disable iff (reset)
        $rose(gate_q) |-> on_cnt_q == 16'h0000)
        else $error("on time did not restart at turn-on");
    a_off_sat: assert property (@(posedge core_clk) disable iff (reset)
        off_cnt_q <= MAX_OFF_CYC - 16'h0001)
        else $error("off time counter ran past its limit");
    a_on_sat: assert property (@(posedge core_clk) disable iff (reset)
        on_cnt_q <= MAX_ON_CYC - 16'h0001)
        else $error("on time counter ran past its limit");
    a_zc_hold_on: assert property (@(posedge core_clk) disable iff (reset)
        gate_q |=> $stable(zc_cnt_q))
        else $error("crossing counter moved while the gate was on");
    a_zc_saturate: assert property (@(posedge core_clk) disable iff (reset)
        zc_cnt_q == `QRST_ZC_MAX && !turn_on |=> zc_cnt_q == `QRST_ZC_MAX)
        else $error("crossing counter left its top value");

    // start-up and protection; turn_on is gated by ovp_trip, so a latch can never
    // coincide with a fresh pulse
    a_wait_gate_low: assert property (@(posedge core_clk) disable iff (reset)
        startup_source_en |-> !gate_q)
        else $error("gate driven while the start-up source was on");
    a_run_from_start: assert property (@(posedge core_clk) disable iff (reset)
        $rose(running) |-> $past(start_evt))
        else $error("switching began without a start event");
    a_restart_one: assert property (@(posedge core_clk) disable iff (reset)
        start_evt |=> valley_index == `QRST_VALLEY_MIN)
        else $error("valley index not one after start-up");
    a_ovp_latch: assert property (@(posedge core_clk) disable iff (reset)
        running && ovp_trip |=> latched_off)
        else $error("persistent overvoltage did not latch off");
    a_ovp_on_clear: assert property (@(posedge core_clk) disable iff (reset)
        gate_q |=> ovp_cnt_q == 16'h0000)
        else $error("overvoltage blanking not restarted by a pulse");
    a_latch_gate_low: assert property (@(posedge core_clk) disable iff (reset)
        $rose(latched_off) |-> !gate_q)
        else $error("gate high when the latch engaged");
    a_sync_second_flop: assert property (@(posedge core_clk) disable iff (reset)
        sync_q == $past(meta_q))
        else $error("synchroniser skipped its second flop");
    c_valley_on: cover property (@(posedge core_clk) disable iff (reset)
        turn_on && valley_ok && fbi.valley_idx > 3'h1);
    c_max_off_on: cover property (@(posedge core_clk) disable iff (reset)
        turn_on && !valley_ok);
    c_latch: cover property (@(posedge core_clk) disable iff (reset) $rose(latched_off));
    c_ss_done: cover property (@(posedge core_clk) disable iff (reset) $fell(ss_busy_q));
endmodule

// ==== design/qrst_consts.svh ====
// constants and timing figures for the quasi-resonant switch timing core
// Behaviour
// - on supply above turn-on threshold, stop start-up source and begin soft-start switching
// - soft-start is purely timed, 12ms total in 4 equal steps
// - soft-start raises peak limit stepwise from 0.32V to 1V
// - turn-on comes from counter logic, turn-off from analog feedback/sense comparison
// - up/down counter holds the valley index used for turn-on
// - feedback is judged against three thresholds each 48ms period, counter updated once
// - feedback always below low threshold: count up, saturate at 7
// - above low but never above high threshold: keep the value
// - above high but never above reset threshold: count down, saturate at 1
// - above reset threshold: force counter to 1
// - counter starts at 1 at start-up
// - counter stays within 1 to 7, attempts beyond are ignored
// - low and high feedback thresholds follow the line voltage level
// - zero-crossing counter stays within 0 to 7
// - after turn-off each falling zero crossing adds one to the crossing counter
// - crossing counter clears whenever the gate goes high
// - crossing input above overvoltage level while off, past blanking, latches off
// - after gate falls it stays low until ringing suppression expires
// - after ringing suppression, turn on when crossings reach the valley index
// - gate off for max_off_time turns on regardless of counters
// - gate high longer than maximum on time is forced low
`ifndef QRST_CONSTS_SVH
`define QRST_CONSTS_SVH

`define QRST_CLK_KHZ 100000
`define QRST_CLK_NS 10
`define QRST_FB_PERIOD_MS 48
`define QRST_FB_PERIOD_CYC (`QRST_FB_PERIOD_MS * `QRST_CLK_KHZ)
`define QRST_SS_TOTAL_MS 12
`define QRST_SS_STEPS 4
`define QRST_SS_STEP_CYC (`QRST_SS_TOTAL_MS * `QRST_CLK_KHZ / `QRST_SS_STEPS)
`define QRST_SS_LAST_STEP 2'h3
`define QRST_MAX_OFF_US 50
`define QRST_MAX_OFF_CYC (`QRST_MAX_OFF_US * `QRST_CLK_KHZ / 1000)
`define QRST_RING_NS 2500
`define QRST_RING_CYC ((`QRST_RING_NS + `QRST_CLK_NS - 1) / `QRST_CLK_NS)
`define QRST_MAX_ON_NS 30000
`define QRST_MAX_ON_CYC (`QRST_MAX_ON_NS / `QRST_CLK_NS)
`define QRST_OVP_BLANK_NS 2000
`define QRST_OVP_BLANK_CYC ((`QRST_OVP_BLANK_NS + `QRST_CLK_NS - 1) / `QRST_CLK_NS)
`define QRST_VALLEY_MIN 3'h1
`define QRST_VALLEY_MAX 3'h7
`define QRST_ZC_MAX 3'h7
`define QRST_SYNC_W 8

`endif

// ==== design/qrst_pkg.sv ====
// shared types of the quasi-resonant switch timing core
package qrst_pkg;
    typedef logic [2:0] qrst_count_t;
    typedef enum logic [2:0] {
        QRST_WAIT  = 3'b001,
        QRST_RUN   = 3'b010,
        QRST_LATCH = 3'b100
    } qrst_state_e;
endpackage

// ==== design/qrst_fb_if.sv ====
// carrier between the switch core and the valley counter
`timescale 1ns/100ps
interface qrst_fb_if;
    import qrst_pkg::*;
    logic fb_low;
    logic fb_high;
    logic fb_reset;
    logic restart;
    qrst_count_t valley_idx;
    modport ctrl (output fb_low, output fb_high, output fb_reset, output restart,
        input valley_idx);
    modport counter (input fb_low, input fb_high, input fb_reset, input restart,
        output valley_idx);
endinterface

// ==== design/qrst_valley_counter.sv ====
// load-dependent up/down valley counter, judged once per feedback period
`timescale 1ns/100ps
`include "qrst_consts.svh"
module qrst_valley_counter
    import qrst_pkg::*;
#(
    parameter logic [22:0] PERIOD_CYC = 23'(`QRST_FB_PERIOD_CYC)
)(
    input wire logic core_clk,
    input wire logic reset,
    qrst_fb_if.counter fb
);
    logic [22:0] per_cnt_q;
    logic seen_low_q;
    logic seen_high_q;
    logic seen_rst_q;
    qrst_count_t idx_q;
    logic per_end;
    logic any_low;
    logic any_high;
    logic any_rst;
    qrst_count_t idx_up;
    qrst_count_t idx_dn;
    qrst_count_t idx_d;

    // the sample of the final cycle still counts toward this period
    assign per_end = (per_cnt_q == PERIOD_CYC - 23'h000001);
    assign any_low = seen_low_q | fb.fb_low;
    assign any_high = seen_high_q | fb.fb_high;
    assign any_rst = seen_rst_q | fb.fb_reset;
    assign idx_up = (idx_q == `QRST_VALLEY_MAX) ? idx_q : idx_q + 3'h1;
    assign idx_dn = (idx_q == `QRST_VALLEY_MIN) ? idx_q : idx_q - 3'h1;
    assign idx_d = any_rst ? `QRST_VALLEY_MIN
        : any_high ? idx_dn
        : any_low ? idx_q
        : idx_up;
    assign fb.valley_idx = idx_q;

    // period timer and sticky threshold flags
    always_ff @(posedge core_clk)
    begin
        if (reset || fb.restart || per_end)
        begin
            per_cnt_q <= 23'h000000;
            seen_low_q <= 1'b0;
            seen_high_q <= 1'b0;
            seen_rst_q <= 1'b0;
        end
        else
        begin
            per_cnt_q <= per_cnt_q + 23'h000001;
            seen_low_q <= any_low;
            seen_high_q <= any_high;
            seen_rst_q <= any_rst;
        end
    end

    // one update per period; start-up gives full load capability
    always_ff @(posedge core_clk)
    begin
        if (reset || fb.restart)
            idx_q <= `QRST_VALLEY_MIN;
        else if (per_end)
            idx_q <= idx_d;
    end

    a_udc_range: assert property (@(posedge core_clk) disable iff (reset)
        idx_q >= `QRST_VALLEY_MIN && idx_q <= `QRST_VALLEY_MAX)
        else $error("valley index out of range");
    a_udc_force_one: assert property (@(posedge core_clk) disable iff (reset)
        per_end && any_rst && !fb.restart |=> idx_q == `QRST_VALLEY_MIN)
        else $error("reset threshold did not force index to one");
    a_udc_count_up: assert property (@(posedge core_clk) disable iff (reset)
        per_end && !any_low && !any_high && !any_rst && !fb.restart
        |=> idx_q == (($past(idx_q) == 3'h7) ? 3'h7 : $past(idx_q) + 3'h1))
        else $error("index did not count up on a light period");
    a_udc_hold_mid: assert property (@(posedge core_clk) disable iff (reset)
        !per_end && !fb.restart |=> $stable(idx_q))
        else $error("index changed inside a period");
    c_udc_top: cover property (@(posedge core_clk) disable iff (reset) idx_q == 3'h7);
endmodule

// ==== test/qrst_analog_model.sv ====
// behavioural analog front end: turn-off comparator and auxiliary-winding ringing
`timescale 1ns/100ps
module qrst_analog_model (
    input wire logic core_clk,
    input wire logic gate_drive_output,
    input wire logic [15:0] on_cyc,
    output logic cs_trip,
    output logic zc_above_zero
);
    int on_t = 0;
    int off_t = 1000;

    initial
    begin
        cs_trip = 1'b0;
        zc_above_zero = 1'b0;
    end

    // sense ramp trips after on_cyc high cycles; zero models a load that never trips
    always @(posedge core_clk)
    begin
        on_t = gate_drive_output ? on_t + 1 : 0;
        off_t = gate_drive_output ? 0 : off_t + 1;
        cs_trip <= (on_cyc != 16'h0000) && (on_t >= on_cyc);
        // seven falling crossings 60 cycles apart, then the ringing has damped out
        zc_above_zero <= (off_t > 0) && (off_t < 460) && (off_t < 100 || (off_t - 100) % 60 >= 30);
    end
endmodule

// ==== test/qrst_switch_timing_tb_top.sv ====
// self-checking bench of the switch timing core with the analog model
`timescale 1ns/100ps
module qrst_switch_timing_tb_top;
    import qrst_pkg::*;
    localparam int PER = 200;
    localparam int MOFF = 400;
    localparam int NPER = 19;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic supply_above_on = 1'b0;
    logic fb_above_low = 1'b0;
    logic fb_above_high = 1'b0;
    logic fb_above_reset = 1'b0;
    logic line_high = 1'b0;
    logic zc_above_ovp = 1'b0;
    logic [15:0] on_cyc = 16'h0064;
    logic cs_trip, zc_above_zero, gate_drive_output, startup_source_en, fb_thr_line_sel;
    logic softstart_active, latched_off;
    logic [1:0] peak_limit_step;
    qrst_count_t valley_index, zc_count, v_fall;
    qrst_count_t vexp = 3'h1;
    qrst_count_t exp_q[$];
    int error_cnt = 0;
    int checks = 0;
    int off_len = 0;
    int on_len = 0;
    int lo, hi_cnt;
    bit running = 0;
    int codes[NPER] = '{0, 0, 0, 0, 0, 0, 0, 1, 2, 3, 2, 0, 1, 0, 0, 0, 0, 0, 0};

    always #5 core_clk = ~core_clk;

    qrst_switch_timing #(.FB_PERIOD_CYC(23'h0000C8), .SS_STEP_CYC(19'h00032),
        .MAX_OFF_CYC(16'h0190)) i_dut (.core_clk(core_clk), .reset(reset),
        .supply_above_on(supply_above_on), .fb_above_low(fb_above_low),
        .fb_above_high(fb_above_high), .fb_above_reset(fb_above_reset),
        .line_high(line_high), .cs_trip(cs_trip), .zc_above_zero(zc_above_zero),
        .zc_above_ovp(zc_above_ovp), .gate_drive_output(gate_drive_output),
        .startup_source_en(startup_source_en), .fb_thr_line_sel(fb_thr_line_sel),
        .softstart_active(softstart_active), .peak_limit_step(peak_limit_step),
        .valley_index(valley_index), .zc_count(zc_count), .latched_off(latched_off));

    qrst_analog_model i_analog (.core_clk(core_clk), .gate_drive_output(gate_drive_output),
        .on_cyc(on_cyc), .cs_trip(cs_trip), .zc_above_zero(zc_above_zero));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // bounded wait for soft-start (sel 0) or the latch (sel 1)
    task automatic wait_hi(input int sel, input int lim);
        int k;
        k = 0;
        while (((sel == 0) ? softstart_active : latched_off) !== 1'b1)
        begin
            @(negedge core_clk);
            k++;
            if (k > lim)
            begin
                error_cnt++;
                finish_test();
            end
        end
    endtask

    // bounded wait for the gate to be low, then one edge more so the watcher
    // judges the finished pulse against the load it really had
    task automatic wait_gate_low(input int lim);
        int k;
        k = 0;
        while (gate_drive_output !== 1'b0)
        begin
            @(negedge core_clk);
            k++;
            if (k > lim)
            begin
                error_cnt++;
                finish_test();
            end
        end
        @(negedge core_clk);
    endtask

    function automatic qrst_count_t nxt(input qrst_count_t v, input int c);
        case (c)
            0: return (v == 3'h7) ? v : v + 3'h1;
            1: return v;
            2: return (v == 3'h1) ? v : v - 3'h1;
            default: return 3'h1;
        endcase
    endfunction

    // gate watcher: off time limits, valley choice and on time limits per pulse
    always @(negedge core_clk)
    begin
        if (!running)
        begin
            off_len = 0;
            on_len = 0;
        end
        else if (gate_drive_output === 1'b1)
        begin
            if (on_len == 0 && off_len > 0)
            begin
                lo = (v_fall > 3'h6) ? MOFF : 100 + 60 * (int'(v_fall) - 1);
                lo = (lo < 250) ? 250 : lo;
                check(off_len >= 250 && off_len <= MOFF, 1);
                if (valley_index === v_fall)
                    check(off_len >= lo && off_len <= lo + 6, 1);
                check(zc_count, 0);
            end
            on_len++;
            off_len = 0;
        end
        else
        begin
            if (on_len > 0 && on_cyc == 16'h0000)
                check(on_len, 3000);
            else if (on_len > 0)
                check(on_len <= int'(on_cyc) + 5, 1);
            if (on_len > 0)
                v_fall = valley_index;
            on_len = 0;
            off_len++;
        end
    end

    // a hang anywhere ends the run as a mismatch
    initial
    begin
        repeat (100000) @(posedge core_clk);
        error_cnt++;
        $display("run limit reached at %0t", $time);
        finish_test();
    end

    initial
    begin
        void'($urandom(32'h414B));
        for (int k = 13; k < NPER; k++)
            codes[k] = $urandom % 4;
        repeat (10) @(negedge core_clk);
        reset = 1'b0;
        check(valley_index, 1);
        check(startup_source_en, 1);
        repeat (5) @(negedge core_clk);
        check(gate_drive_output, 0);
        supply_above_on = 1'b1;
        wait_hi(0, 20);
        running = 1;
        check(startup_source_en, 0);
        fork
            // feedback driver: one feedback class per period, noting the expected index
            for (int k = 0; k < NPER; k++)
            begin
                vexp = nxt(vexp, codes[k]);
                exp_q.push_back(vexp);
                line_high = 1'($urandom);
                repeat (40) @(negedge core_clk);
                check(fb_thr_line_sel, line_high);
                fb_above_low = (codes[k] >= 1);
                fb_above_high = (codes[k] >= 2);
                fb_above_reset = (codes[k] == 3);
                repeat (10) @(negedge core_clk);
                {fb_above_low, fb_above_high, fb_above_reset} = 3'h0;
                repeat (PER - 50) @(negedge core_clk);
            end
            // monitor: index sampled mid-period, after the previous period's update
            begin
                repeat (PER / 2) @(negedge core_clk);
                for (int k = 0; k < NPER; k++)
                begin
                    repeat (PER) @(negedge core_clk);
                    check(valley_index, exp_q.pop_front());
                end
            end
            // soft-start steps, read in the middle of each step
            begin
                repeat (25) @(negedge core_clk);
                for (int k = 0; k < 4; k++)
                begin
                    check(peak_limit_step, k);
                    repeat (50) @(negedge core_clk);
                end
                check(softstart_active, 0);
                check(peak_limit_step, 3);
            end
        join
        $display("soft-start and valley counter test done");
        // the sense load only changes inside an off time
        wait_gate_low(400);
        on_cyc = 16'h0000;
        repeat (3500) @(negedge core_clk);
        wait_gate_low(3100);
        on_cyc = 16'h0064;
        $display("maximum on time test done");
        // an overvoltage shorter than the blanking must not latch
        zc_above_ovp = 1'b1;
        repeat (100) @(negedge core_clk);
        zc_above_ovp = 1'b0;
        repeat (10) @(negedge core_clk);
        check(latched_off, 0);
        zc_above_ovp = 1'b1;
        wait_hi(1, 1200);
        running = 0;
        zc_above_ovp = 1'b0;
        hi_cnt = 0;
        repeat (300)
        begin
            @(negedge core_clk);
            if (gate_drive_output !== 1'b0)
                hi_cnt++;
        end
        check(hi_cnt, 0);
        check(latched_off, 1);
        check(zc_count, 3'h7);
        reset = 1'b1;
        repeat (10) @(negedge core_clk);
        reset = 1'b0;
        @(negedge core_clk);
        check(latched_off, 0);
        check(valley_index, 1);
        check(startup_source_en, 1);
        $display("latch-off test done");
        finish_test();
    end
endmodule
